// *** hw/ghp_consts.vh ***
// Shared constants for the graphics host bus port.
`ifndef GHP_CONSTS_VH
`define GHP_CONSTS_VH

// Widths of the host address and shared data buses.
`define GHP_ADDR_W      22
`define GHP_DATA_W      16

// Number of host strobe and grant lines that pass through the sampling stage.
`define GHP_SYNC_W      4

// Bit positions of the sampled strobes and grant inside the sampling vector.
`define GHP_SB_RD       0
`define GHP_SB_WR       1
`define GHP_SB_CS       2
`define GHP_SB_GNT      3

// Reset values of the captured straps.
`define GHP_RST_SYNC    1'h0
`define GHP_RST_STYLE   1'h0
`define GHP_RST_TEST    2'h3

// Value of the divider flop that means phase 2 is current.
`define GHP_PHASE2      1'h1

// Default byte address of the interrupt register inside the host memory interface.
`define GHP_INTREG_ADDR 22'h00002A

// Depth of the internal reset synchroniser.
`define GHP_RST_STAGES  2

`endif

// *** hw/ghp_rst.v ***
// Internal reset synchroniser: asynchronous assertion, clocked release.
`timescale 1ns/1ps
`include "ghp_consts.vh"
module ghp_rst #(
   parameter STAGES = `GHP_RST_STAGES
) (
   input  wire i_clk,
   input  wire i_rst_n,
   output wire o_rst_n
);

   reg [STAGES-1:0] chain_ff;   // Shift chain of ones after release.

   // Assertion is immediate so activity halts at once; release waits for the clock.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chain_ff <= {STAGES{1'b0}};
      end else begin
         chain_ff <= {chain_ff[STAGES-2:0], 1'b1};
      end
   end

   assign o_rst_n = chain_ff[STAGES-1];

endmodule

// *** hw/ghp_sync.v ***
// Two-flop sampling stage for host strobes with a strap-selected bypass.
`timescale 1ns/1ps
module ghp_sync #(
   parameter WIDTH = 4
) (
   input  wire             i_clk,
   input  wire             i_rst_n,
   input  wire             i_bypass,
   input  wire [WIDTH-1:0] i_raw,
   output wire [WIDTH-1:0] o_smp
);

   reg [WIDTH-1:0] meta_ff;   // First stage, read only by the second stage.
   reg [WIDTH-1:0] stab_ff;   // Second stage, safe to use.

   // Strobes idle high, so both stages reset to the inactive level.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= {WIDTH{1'b1}};
         stab_ff <= {WIDTH{1'b1}};
      end else begin
         meta_ff <= i_raw;
         stab_ff <= meta_ff;
      end
   end

   // In synchronous mode the pins already meet setup, so the two-cycle delay is skipped.
   assign o_smp = i_bypass ? i_raw : stab_ff;

endmodule

// *** hw/ghp_top.v ***
// Host bus port: slave access, bus hold master cycles, straps, interrupt and clock phase.
//
// Overview of operation
// - Upper byte strobe at reset picks sampling mode.
// - Memory/IO select at reset picks bus style.
// - Read and write strobes at reset pick test.
// - Address lines driven only while owning bus.
// - Upper byte strobe driven low as master.
// - Memory/IO select driven high as master.
// - Slave cycle valid only with chip select.
// - Master enable high exactly while owning bus.
// - Slave enable high from completion until strobe release.
// - Ready sampled synchronously; cycle waits for it.
// - Hold request high while engines need bus.
// - Interrupt set by a rising edge of either engine interrupt.
// - Interrupt register access clears the interrupt.
// - Reset synchronised internally; all logic initialised.
// - Reset leading edge forces phase 2.
// - Double clock divided by two into phases.
// - One shared 16-bit data bus.
// - Drop hold request when unneeded outside a running cycle, or when grant lost.
// - Drive bus lines only after grant received.
// - New slave command waits for previous completion.
// - Slave accesses served while awaiting grant.
`timescale 1ns/1ps
`include "ghp_consts.vh"
module ghp_top #(
   parameter AW          = `GHP_ADDR_W,
   parameter DW          = `GHP_DATA_W,
   parameter INTREG_ADDR = `GHP_INTREG_ADDR
) (
   input  wire          I_MCLK,
   input  wire          I_RSTN,
   // Host address pins.
   input  wire [AW-1:0] I_HOST_ADDR,
   output reg  [AW-1:0] O_HOST_ADDR,
   output wire          O_HOST_ADDR_OE,
   // Shared data bus pins.
   input  wire [DW-1:0] I_SHARED_DATA_BUS,
   output reg  [DW-1:0] O_SHARED_DATA_BUS,
   output wire          O_SHARED_DATA_BUS_OE,
   // Host strobe pins.
   input  wire          I_UPPER_BYTE_STROBE_N,
   output reg           O_UPPER_BYTE_STROBE_N,
   output wire          O_UPPER_BYTE_STROBE_OE,
   input  wire          I_RD_N,
   output reg           O_RD_N,
   output wire          O_RD_OE,
   input  wire          I_WR_N,
   output reg           O_WR_N,
   output wire          O_WR_OE,
   input  wire          I_MEM_IO,
   output wire          O_MEM_IO,
   output wire          O_MEM_IO_OE,
   input  wire          I_CS_N,
   input  wire          I_READY_N,
   // Bus ownership, slave enable and interrupt pins.
   output wire          O_MASTER_DRIVE_FLAG,
   output wire          O_SLAVE_DONE_FLAG,
   output reg           O_BUS_HOLD_REQUEST,
   input  wire          I_BUS_HOLD_GRANT,
   output reg           O_INTERRUPT_OUT,
   // Engine side of master cycles.
   input  wire          I_DISP_NEED,
   input  wire          I_DRAW_NEED,
   input  wire          I_MST_REQ,
   input  wire [AW-1:0] I_MST_ADDR,
   input  wire          I_MST_WE,
   input  wire [DW-1:0] I_MST_WDATA,
   output reg           O_MST_ACK,
   output reg  [DW-1:0] O_MST_RDATA,
   // Internal side of slave cycles.
   output reg           O_SLV_REQ,
   output reg  [AW-1:0] O_SLV_ADDR,
   output reg           O_SLV_WE,
   output reg           O_SLV_MEM_IO,
   output reg           O_SLV_UB_N,
   output reg  [DW-1:0] O_SLV_WDATA,
   input  wire          I_SLV_DONE,
   input  wire [DW-1:0] I_SLV_RDATA,
   // Engine interrupts.
   input  wire          I_DRAW_INT,
   input  wire          I_DISP_INT,
   // Captured straps and clock phase.
   output reg           O_SYNC_MODE,
   output reg           O_BUS_STYLE,
   output reg  [1:0]    O_TEST_MODE,
   output reg           O_PHASE2
);

   // Slave states, one-hot.
   localparam [3:0] S_IDLE = 4'h1;   // Watching the strobes.
   localparam [3:0] S_BUSY = 4'h2;   // Internal logic services the access.
   localparam [3:0] S_DONE = 4'h4;   // Slave enable high, waiting for strobe release.

   // Master states, one-hot.
   localparam [3:0] M_IDLE = 4'h1;   // Bus not needed.
   localparam [3:0] M_REQ  = 4'h2;   // Hold request raised, awaiting grant.
   localparam [3:0] M_OWN  = 4'h4;   // Bus owned, no cycle running.
   localparam [3:0] M_CYC  = 4'h8;   // Cycle running, awaiting ready.

   wire                  rst_n;       // Synchronised reset.
   wire [`GHP_SYNC_W-1:0] smp;        // Sampled strobes and grant.
   reg  [3:0]            s_ff;        // Slave state.
   reg  [3:0]            nxt_s;
   reg  [3:0]            m_ff;        // Master state.
   reg  [3:0]            nxt_m;
   reg                   rd_drv_ff;   // Drive read data to the host.
   reg  [DW-1:0]         slv_rdata_ff; // Read data returned to the host.
   reg  [DW-1:0]         m_wdata_ff;  // Write data held during a master cycle.
   reg                   m_we_ff;     // Direction of the running master cycle.
   reg                   draw_int_ff; // Previous engine interrupt levels.
   reg                   disp_int_ff;
   wire                  need;        // Some engine needs the external bus.
   wire                  gnt;         // Grant as seen by the logic.
   wire                  slv_cmd;     // Host cycle aimed at this device.
   wire                  int_set;
   wire                  int_clr;

   // Straps choose sampling, so they gate the bypass of the sampling stage.
   ghp_rst #(
      .STAGES (`GHP_RST_STAGES)
   ) u_rst (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RSTN),
      .o_rst_n (rst_n)
   );

   ghp_sync #(
      .WIDTH (`GHP_SYNC_W)
   ) u_sync (
      .i_clk    (I_MCLK),
      .i_rst_n  (rst_n),
      .i_bypass (O_SYNC_MODE),
      .i_raw    ({~I_BUS_HOLD_GRANT, I_CS_N, I_WR_N, I_RD_N}),
      .o_smp    (smp)
   );

   // True when a slave address hits the interrupt register.
   function is_intreg;
      input [AW-1:0] a;
      begin
         is_intreg = (a == INTREG_ADDR);
      end
   endfunction

   // Straps reload after the external release while the internal reset is held; the last load is its release edge.
   always @(posedge I_MCLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         O_SYNC_MODE <= `GHP_RST_SYNC;
         O_BUS_STYLE <= `GHP_RST_STYLE;
         O_TEST_MODE <= `GHP_RST_TEST;
      end else if (!rst_n) begin
         O_SYNC_MODE <= I_UPPER_BYTE_STROBE_N;
         O_BUS_STYLE <= I_MEM_IO;
         O_TEST_MODE <= {I_WR_N, I_RD_N};
      end
   end

   // Divide-by-two phase; held at phase 2 from the leading edge of reset.
   always @(posedge I_MCLK or negedge rst_n) begin
      if (!rst_n) begin
         O_PHASE2 <= `GHP_PHASE2;
      end else begin
         O_PHASE2 <= ~O_PHASE2;
      end
   end

   assign need    = I_DISP_NEED | I_DRAW_NEED;
   assign gnt     = ~smp[`GHP_SB_GNT];   // Sampled inverted: reset ones mean no grant.
   // A cycle counts only while chip select qualifies a strobe.
   assign slv_cmd = ~smp[`GHP_SB_CS] & (~smp[`GHP_SB_RD] | ~smp[`GHP_SB_WR]);

   // Slave state choice; a new command is taken only from idle.
   always @* begin
      nxt_s = s_ff;
      case (s_ff)
         S_IDLE: begin
            if (slv_cmd) begin
               nxt_s = S_BUSY;
            end
         end
         S_BUSY: begin
            if (I_SLV_DONE) begin
               nxt_s = S_DONE;
            end
         end
         S_DONE: begin
            // The host holds the strobe until it sees ready; wait for its release.
            if (smp[`GHP_SB_RD] & smp[`GHP_SB_WR]) begin
               nxt_s = S_IDLE;
            end
         end
         default: begin
            nxt_s = S_IDLE;
         end
      endcase
   end

   // Slave state, captured access and read data.
   always @(posedge I_MCLK or negedge rst_n) begin
      if (!rst_n) begin
         s_ff         <= S_IDLE;
         O_SLV_REQ    <= 1'b0;
         O_SLV_ADDR   <= {AW{1'b0}};
         O_SLV_WE     <= 1'b0;
         O_SLV_MEM_IO <= 1'b0;
         O_SLV_UB_N   <= 1'b1;
         O_SLV_WDATA  <= {DW{1'b0}};
         rd_drv_ff    <= 1'b0;
         slv_rdata_ff <= {DW{1'b0}};
      end else begin
         s_ff      <= nxt_s;
         O_SLV_REQ <= (s_ff == S_IDLE) & slv_cmd;
         if ((s_ff == S_IDLE) & slv_cmd) begin
            O_SLV_ADDR   <= I_HOST_ADDR;
            O_SLV_WE     <= ~smp[`GHP_SB_WR];
            O_SLV_MEM_IO <= I_MEM_IO;
            O_SLV_UB_N   <= I_UPPER_BYTE_STROBE_N;
            O_SLV_WDATA  <= I_SHARED_DATA_BUS;
         end
         // Read data goes out only for reads, and stops when the strobe lifts.
         rd_drv_ff <= (nxt_s == S_DONE) & ~O_SLV_WE;
         // Read data is taken with the completion so it stands through the done phase.
         if ((s_ff == S_BUSY) & I_SLV_DONE) begin
            slv_rdata_ff <= I_SLV_RDATA;
         end
      end
   end

   // Slave enable doubles as data path enable and ready.
   assign O_SLAVE_DONE_FLAG = (s_ff == S_DONE);

   // Master state choice.
   always @* begin
      nxt_m = m_ff;
      case (m_ff)
         M_IDLE: begin
            if (need) begin
               nxt_m = M_REQ;
            end
         end
         M_REQ: begin
            if (!need) begin
               nxt_m = M_IDLE;
            end else if (gnt) begin
               nxt_m = M_OWN;
            end
         end
         M_OWN: begin
            if (!need | !gnt) begin
               nxt_m = M_IDLE;
            end else if (I_MST_REQ) begin
               nxt_m = M_CYC;
            end
         end
         M_CYC: begin
            // Losing the grant aborts; the engine must retry the cycle.
            if (!gnt) begin
               nxt_m = M_IDLE;
            end else if (!I_READY_N) begin
               nxt_m = M_OWN;
            end
         end
         default: begin
            nxt_m = M_IDLE;
         end
      endcase
   end

   // Master state, request line, pin values and cycle results.
   always @(posedge I_MCLK or negedge rst_n) begin
      if (!rst_n) begin
         m_ff                  <= M_IDLE;
         O_BUS_HOLD_REQUEST    <= 1'b0;
         O_HOST_ADDR           <= {AW{1'b0}};
         O_RD_N                <= 1'b1;
         O_WR_N                <= 1'b1;
         O_UPPER_BYTE_STROBE_N <= 1'b1;
         m_wdata_ff            <= {DW{1'b0}};
         m_we_ff               <= 1'b0;
         O_MST_ACK             <= 1'b0;
         O_MST_RDATA           <= {DW{1'b0}};
      end else begin
         m_ff               <= nxt_m;
         O_BUS_HOLD_REQUEST <= (nxt_m != M_IDLE);
         O_MST_ACK          <= (m_ff == M_CYC) & gnt & ~I_READY_N;
         if ((m_ff == M_OWN) & (nxt_m == M_CYC)) begin
            O_HOST_ADDR <= I_MST_ADDR;
            m_wdata_ff  <= I_MST_WDATA;
            m_we_ff     <= I_MST_WE;
         end
         if ((m_ff == M_CYC) & gnt & ~I_READY_N & ~m_we_ff) begin
            O_MST_RDATA <= I_SHARED_DATA_BUS;
         end
         O_RD_N                <= ~((nxt_m == M_CYC) & ~((m_ff == M_CYC) ? m_we_ff : I_MST_WE));
         O_WR_N                <= ~((nxt_m == M_CYC) & ((m_ff == M_CYC) ? m_we_ff : I_MST_WE));
         O_UPPER_BYTE_STROBE_N <= ~((nxt_m == M_OWN) | (nxt_m == M_CYC));
      end
   end

   // Ownership begins only once the grant has answered the request.
   assign O_MASTER_DRIVE_FLAG    = (m_ff == M_OWN) | (m_ff == M_CYC);
   assign O_HOST_ADDR_OE         = O_MASTER_DRIVE_FLAG;
   assign O_UPPER_BYTE_STROBE_OE = O_MASTER_DRIVE_FLAG;
   assign O_RD_OE                = O_MASTER_DRIVE_FLAG;
   assign O_WR_OE                = O_MASTER_DRIVE_FLAG;
   assign O_MEM_IO_OE            = O_MASTER_DRIVE_FLAG;
   assign O_MEM_IO               = 1'b1;

   // Shared data bus: master writes or slave reads; slave read data wins when both are enabled.
   always @* begin
      O_SHARED_DATA_BUS = rd_drv_ff ? slv_rdata_ff : m_wdata_ff;
   end
   assign O_SHARED_DATA_BUS_OE = rd_drv_ff | ((m_ff == M_CYC) & m_we_ff);

   // Interrupt: a rising engine interrupt sets it, a slave access to the register
   // clears it, and a set in the clearing cycle wins so no event is lost.
   assign int_set = (I_DRAW_INT & ~draw_int_ff) | (I_DISP_INT & ~disp_int_ff);
   assign int_clr = O_SLV_REQ & is_intreg(O_SLV_ADDR);
   always @(posedge I_MCLK or negedge rst_n) begin
      if (!rst_n) begin
         draw_int_ff     <= 1'b0;
         disp_int_ff     <= 1'b0;
         O_INTERRUPT_OUT <= 1'b0;
      end else begin
         draw_int_ff <= I_DRAW_INT;
         disp_int_ff <= I_DISP_INT;
         if (int_set) begin
            O_INTERRUPT_OUT <= 1'b1;
         end else if (int_clr) begin
            O_INTERRUPT_OUT <= 1'b0;
         end
      end
   end

endmodule

// *** tb/ghp_host_model.sv ***
// Bus owner model: grants the hold request and answers master cycles with ready.
`timescale 1ns/1ps
module ghp_host_model (
   input  wire       i_clk,
   input  wire       i_rst_n,
   input  wire       i_hold_req,
   input  wire       i_cyc,
   input  wire [3:0] i_gnt_dly,
   input  wire [3:0] i_rdy_dly,
   input  wire       i_revoke,
   output reg        o_grant,
   output reg        o_ready_n
);
   reg [3:0] g_cnt_ff; // Cycles the hold request has waited.
   reg [3:0] r_cnt_ff; // Cycles the current master cycle has waited.
   // Grant comes late on purpose so the port must keep serving slaves meanwhile.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         g_cnt_ff  <= 4'h0;
         r_cnt_ff  <= 4'h0;
         o_grant   <= 1'b0;
         o_ready_n <= 1'b1;
      end else begin
         g_cnt_ff  <= !i_hold_req ? 4'h0 : ((g_cnt_ff != 4'hF) ? g_cnt_ff + 4'h1 : g_cnt_ff);
         o_grant   <= i_hold_req && !i_revoke && (g_cnt_ff >= i_gnt_dly);
         r_cnt_ff  <= i_cyc ? ((r_cnt_ff != 4'hF) ? r_cnt_ff + 4'h1 : r_cnt_ff) : 4'h0;
         o_ready_n <= !(i_cyc && (r_cnt_ff >= i_rdy_dly));
      end
   end
endmodule

// *** tb/ghp_top_asserts.sv ***
// Checker that watches the host bus port pins of the top module.
`timescale 1ns/1ps
module ghp_top_chk #(
   parameter AW          = 22,
   parameter INTREG_ADDR = 22'h00002A
) (
   input wire          I_MCLK,
   input wire          I_RSTN,
   input wire          I_CS_N,
   input wire          I_READY_N,
   input wire          I_BUS_HOLD_GRANT,
   input wire          I_SLV_DONE,
   input wire          I_DRAW_INT,
   input wire          I_DISP_INT,
   input wire          I_DISP_NEED,
   input wire          I_DRAW_NEED,
   input wire          O_HOST_ADDR_OE,
   input wire          O_MASTER_DRIVE_FLAG,
   input wire          O_UPPER_BYTE_STROBE_N,
   input wire          O_UPPER_BYTE_STROBE_OE,
   input wire          O_MEM_IO,
   input wire          O_MEM_IO_OE,
   input wire          O_BUS_HOLD_REQUEST,
   input wire          O_SLV_REQ,
   input wire [AW-1:0] O_SLV_ADDR,
   input wire          O_SYNC_MODE,
   input wire          O_SLAVE_DONE_FLAG,
   input wire          O_MST_ACK,
   input wire          O_INTERRUPT_OUT
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RSTN);
   // An engine interrupt goes from quiet to active.
   sequence s_int_rise;
      $rose(I_DRAW_INT) || $rose(I_DISP_INT);
   endsequence
   // A slave access lands on the interrupt register with no new interrupt beside it.
   sequence s_int_hit;
      O_SLV_REQ && (O_SLV_ADDR == INTREG_ADDR) && !$rose(I_DRAW_INT) && !$rose(I_DISP_INT);
   endsequence
   a_addr_own: assert property ($rose(O_HOST_ADDR_OE) |->
      $past(I_BUS_HOLD_GRANT) && O_BUS_HOLD_REQUEST)
      else $error("address driven without a received grant");
   a_ub_low_master: assert property (O_MASTER_DRIVE_FLAG |-> O_UPPER_BYTE_STROBE_OE && !O_UPPER_BYTE_STROBE_N)
      else $error("byte strobe not driven low as master");
   a_mem_high_master: assert property (O_MASTER_DRIVE_FLAG |-> O_MEM_IO_OE && O_MEM_IO)
      else $error("memory select not driven high as master");
   a_own_after_req: assert property ($rose(O_MASTER_DRIVE_FLAG) |-> $past(O_BUS_HOLD_REQUEST))
      else $error("bus owned without a hold request");
   a_slave_cs: assert property (O_SYNC_MODE && O_SLV_REQ |-> !$past(I_CS_N))
      else $error("slave command without chip select");
   a_done_cause: assert property ($rose(O_SLAVE_DONE_FLAG) |-> $past(I_SLV_DONE) || $past(I_SLV_DONE, 2))
      else $error("slave done flag without completion");
   a_ack_ready: assert property (O_MST_ACK |-> !$past(I_READY_N) || !$past(I_READY_N, 2))
      else $error("master cycle ended without ready");
   a_req_cause: assert property ($rose(O_BUS_HOLD_REQUEST) |-> $past(I_DISP_NEED || I_DRAW_NEED))
      else $error("hold request raised without need");
   a_req_drop: assert property ((!I_DISP_NEED && !I_DRAW_NEED)[*2] |-> ##[0:4] !O_BUS_HOLD_REQUEST)
      else $error("hold request kept without need");
   a_int_set: assert property (s_int_rise |-> ##[0:2] O_INTERRUPT_OUT)
      else $error("interrupt output not set");
   a_int_clear: assert property (s_int_hit |-> ##[0:2] !O_INTERRUPT_OUT)
      else $error("interrupt output not cleared");
endmodule
bind ghp_top ghp_top_chk #(.AW(AW), .INTREG_ADDR(INTREG_ADDR)) ghp_top_chk_i (.I_MCLK, .I_RSTN,
   .I_CS_N, .I_READY_N, .I_SLV_DONE, .I_DRAW_INT, .I_DISP_INT, .I_DISP_NEED, .I_DRAW_NEED,
   .O_HOST_ADDR_OE, .O_MASTER_DRIVE_FLAG, .O_UPPER_BYTE_STROBE_N, .O_UPPER_BYTE_STROBE_OE,
   .O_MEM_IO, .O_MEM_IO_OE, .O_BUS_HOLD_REQUEST, .O_SLV_REQ, .O_SLV_ADDR, .O_SYNC_MODE,
   .O_SLAVE_DONE_FLAG, .O_MST_ACK, .O_INTERRUPT_OUT, .I_BUS_HOLD_GRANT);

// *** tb/ghp_top_tb.sv ***
// Testbench for the host bus port: straps, slave and master cycles, interrupt.
`timescale 1ns/1ps
`include "ghp_consts.vh"
module ghp_top_tb;
   wire [21:0] O_HOST_ADDR, O_SLV_ADDR, I_HOST_ADDR;
   wire [15:0] O_SHARED_DATA_BUS, O_MST_RDATA, O_SLV_WDATA, I_SHARED_DATA_BUS;
   wire [1:0]  O_TEST_MODE;
   wire O_HOST_ADDR_OE, O_SHARED_DATA_BUS_OE, O_UPPER_BYTE_STROBE_N, O_UPPER_BYTE_STROBE_OE;
   wire O_RD_N, O_RD_OE, O_WR_N, O_WR_OE, O_MEM_IO, O_MEM_IO_OE, O_MASTER_DRIVE_FLAG;
   wire O_SLAVE_DONE_FLAG, O_BUS_HOLD_REQUEST, O_INTERRUPT_OUT, O_MST_ACK, O_SLV_REQ;
   wire O_SLV_WE, O_SLV_MEM_IO, O_SLV_UB_N, O_SYNC_MODE, O_BUS_STYLE, O_PHASE2;
   wire I_UPPER_BYTE_STROBE_N, I_RD_N, I_WR_N, I_MEM_IO, I_READY_N, I_BUS_HOLD_GRANT;
   logic I_MCLK = 0, I_RSTN = 0, I_CS_N = 1, I_DISP_NEED = 0, I_DRAW_NEED = 0, I_MST_REQ = 0;
   logic I_MST_WE = 0, I_SLV_DONE = 0, I_DRAW_INT = 0, I_DISP_INT = 0;
   logic [21:0] I_MST_ADDR = 0, h_addr = 0;
   logic [15:0] I_MST_WDATA = 0, I_SLV_RDATA = 0, h_data = 0;
   logic h_ub = 1, h_rd = 1, h_wr = 1, h_mio = 1, revoke = 0;
   logic [3:0] gdly = 4'h2, rdly = 4'h1;
   int err_total = 0, checks = 0;
   // Each shared line carries whichever party has its enable up.
   assign I_HOST_ADDR = O_HOST_ADDR_OE ? O_HOST_ADDR : h_addr;
   assign I_SHARED_DATA_BUS = O_SHARED_DATA_BUS_OE ? O_SHARED_DATA_BUS : h_data;
   assign I_UPPER_BYTE_STROBE_N = O_UPPER_BYTE_STROBE_OE ? O_UPPER_BYTE_STROBE_N : h_ub;
   assign I_RD_N = O_RD_OE ? O_RD_N : h_rd;
   assign I_WR_N = O_WR_OE ? O_WR_N : h_wr;
   assign I_MEM_IO = O_MEM_IO_OE ? O_MEM_IO : h_mio;
   wire cyc_on = (O_RD_OE & ~O_RD_N) | (O_WR_OE & ~O_WR_N);
   wire [5:0] ev = {cyc_on, O_MST_ACK, O_MASTER_DRIVE_FLAG, O_SLAVE_DONE_FLAG, O_SLV_REQ,
                    O_BUS_HOLD_REQUEST};
   ghp_top ghp_top_i (.*);
   ghp_host_model ghp_host_model_i (.i_clk(I_MCLK), .i_rst_n(I_RSTN),
      .i_hold_req(O_BUS_HOLD_REQUEST), .i_cyc(cyc_on), .i_gnt_dly(gdly), .i_rdy_dly(rdly),
      .i_revoke(revoke), .o_grant(I_BUS_HOLD_GRANT), .o_ready_n(I_READY_N));
   // Clock at 100 MHz.
   initial begin
      forever #5 I_MCLK = ~I_MCLK;
   end
   task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Waits a bounded time for one of the handshake signals to reach a level.
   task automatic wt(input int b, input logic v);
      int n;
      n = 0;
      while (ev[b] !== v && n < 60) begin
         @(posedge I_MCLK);
         n++;
      end
      ck("handshake", v, ev[b]);
   endtask
   // Resets with the given strap levels held until the internal release has passed.
   task automatic rst(input logic ub, input logic mio, input logic rd, input logic wr);
      logic p;
      @(posedge I_MCLK);
      I_RSTN <= 0;
      h_ub <= ub;
      h_mio <= mio;
      h_rd <= rd;
      h_wr <= wr;
      repeat (5) @(posedge I_MCLK);
      ck("phase", 1, O_PHASE2);
      I_RSTN <= 1;
      repeat (3) @(posedge I_MCLK);
      h_ub <= 1;
      h_rd <= 1;
      h_wr <= 1;
      ck("sync", ub, O_SYNC_MODE);
      ck("style", mio, O_BUS_STYLE);
      ck("test", {wr, rd}, O_TEST_MODE);
      @(posedge I_MCLK);
      p = O_PHASE2;
      @(posedge I_MCLK);
      ck("phase", !p, O_PHASE2);
   endtask
   // One slave access; a read also lifts and drops its strobe while busy.
   task automatic sacc(input logic we, input logic [21:0] a, input logic [15:0] d);
      @(posedge I_MCLK);
      I_CS_N <= 0;
      h_addr <= a;
      h_data <= d;
      h_ub <= !we;
      if (we) h_wr <= 0;
      else h_rd <= 0;
      wt(1, 1);
      ck("slv addr", a, O_SLV_ADDR);
      ck("slv we", we, O_SLV_WE);
      ck("slv mio", h_mio, O_SLV_MEM_IO);
      ck("slv ub", !we, O_SLV_UB_N);
      if (we) ck("slv data", d, O_SLV_WDATA);
      if (!we) begin
         h_rd <= 1;
         @(posedge I_MCLK);
         h_rd <= 0;
         repeat (3) @(posedge I_MCLK);
         ck("slv req", 0, O_SLV_REQ);
      end
      I_SLV_DONE <= 1;
      I_SLV_RDATA <= ~d;
      @(posedge I_MCLK);
      I_SLV_DONE <= 0;
      wt(2, 1);
      ck("data oe", !we, O_SHARED_DATA_BUS_OE);
      if (!we) ck("read data", 16'(~d), O_SHARED_DATA_BUS);
      h_rd <= 1;
      h_wr <= 1;
      h_ub <= 1;
      I_CS_N <= 1;
      h_data <= ~d;
      wt(2, 0);
   endtask
   // One master cycle; a slow grant lets a slave access run in the meantime.
   task automatic mcyc(input logic we, input logic [21:0] a, input logic [15:0] d,
                       input logic [3:0] gd);
      gdly <= gd;
      I_DRAW_NEED <= 1;
      wt(0, 1);
      if (gd > 4'h4) sacc(1, 22'h000100, 16'h5A5A);
      wt(3, 1);
      I_MST_REQ <= 1;
      I_MST_ADDR <= a;
      I_MST_WE <= we;
      I_MST_WDATA <= d;
      h_data <= d;
      wt(5, 1);
      I_MST_REQ <= 0;
      ck("rd strobe", we, O_RD_N);
      ck("wr strobe", !we, O_WR_N);
      ck("mst addr", a, O_HOST_ADDR);
      if (we) ck("mst data", d, O_SHARED_DATA_BUS);
      wt(4, 1);
      if (!we) ck("mst rdata", d, O_MST_RDATA);
      I_DRAW_NEED <= 0;
      wt(0, 0);
      wt(3, 0);
   endtask
   // Grant taken away during a stalled cycle: no ack, request dropped.
   task automatic mlost;
      rdly <= 4'hF;
      I_DISP_NEED <= 1;
      wt(3, 1);
      I_MST_REQ <= 1;
      wt(5, 1);
      I_MST_REQ <= 0;
      revoke <= 1;
      wt(0, 0);
      ck("no ack", 0, O_MST_ACK);
      I_DISP_NEED <= 0;
      repeat (4) @(posedge I_MCLK);
      revoke <= 0;
      rdly <= 4'h1;
   endtask
   // Each engine interrupt sets the output; the register access clears it.
   task automatic irq;
      @(posedge I_MCLK);
      I_DRAW_INT <= 1;
      repeat (3) @(posedge I_MCLK);
      ck("int", 1, O_INTERRUPT_OUT);
      sacc(0, `GHP_INTREG_ADDR, 16'h0001);
      ck("int", 0, O_INTERRUPT_OUT);
      I_DRAW_INT <= 0;
      I_DISP_INT <= 1;
      repeat (3) @(posedge I_MCLK);
      ck("int", 1, O_INTERRUPT_OUT);
      sacc(1, `GHP_INTREG_ADDR, 16'h0002);
      ck("int", 0, O_INTERRUPT_OUT);
      I_DISP_INT <= 0;
   endtask
   task close_out;
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      err_total++;
      close_out;
   end
   initial begin
      rst(0, 1, 0, 1);
      sacc(0, 22'h000010, 16'h1234);
      rst(1, 0, 1, 1);
      sacc(1, 22'h3FFFFE, 16'hFFFF);
      sacc(0, 22'h000000, 16'h0001);
      mcyc(0, 22'h200000, 16'hA5C3, 4'h2);
      mcyc(1, 22'h3FFFFF, 16'h0F0F, 4'h9);
      mlost;
      irq;
      ck("sync", 1, O_SYNC_MODE);
      close_out;
   end
endmodule
